// ==== logic/mct_pkg.sv ====
package mct_pkg;

   // ==========================================================
   // Timing
   localparam int unsigned CLK_HZ       = 200_000_000;
   localparam int unsigned TB_TOP_HZ    = 1_000_000;
   localparam int unsigned TB_FAST_HZ   = 5_000_000;
   localparam int unsigned TB_TOP_HALF  = CLK_HZ / (2 * TB_TOP_HZ);
   localparam int unsigned TB_FAST_HALF = CLK_HZ / (2 * TB_FAST_HZ);
   localparam int unsigned TB_LEVELS    = 5;
   localparam int unsigned TB_DECADE    = 10;
   localparam int unsigned CNT_W        = 16;
   localparam int unsigned N_FREQ_DIVIDER_OUTPUT       = 2;

   // ==========================================================
   // Register map
   localparam logic [11:0] CMD_OFS    = 12'h000;
   localparam logic [11:0] STATUS_OFS = 12'h004;
   localparam logic [11:0] FOUT0_OFS  = 12'h008;
   localparam logic [11:0] FOUT1_OFS  = 12'h00c;
   localparam logic [11:0] CNT_BASE   = 12'h040;
   localparam logic [11:0] CNT_STRIDE = 12'h010;
   localparam logic [3:0]  CFG_OFS    = 4'h0;
   localparam logic [3:0]  LOAD_OFS   = 4'h4;
   localparam logic [3:0]  HOLD_OFS   = 4'h8;
   localparam logic [3:0]  VALUE_OFS  = 4'hc;
   localparam int unsigned CMD_OP_LSB = 16;
   localparam int unsigned STAT_OUT_LSB = 16;

   // ==========================================================
   // Encodings
   localparam logic [3:0] GATE_NONE    = 4'h0;
   localparam logic [3:0] GATE_HIGH    = 4'h1;
   localparam logic [3:0] GATE_LOW     = 4'h2;
   localparam logic [3:0] GATE_RISE    = 4'h3;
   localparam logic [3:0] GATE_FALL    = 4'h4;
   localparam logic [3:0] GATE_TC_LO   = 4'h5;
   localparam logic [3:0] GATE_HI_UP   = 4'h6;
   localparam logic [3:0] GATE_HI_DN   = 4'h7;
   localparam logic [3:0] GATE_SPECIAL = 4'h8;

   localparam logic [3:0] SRC_CHAIN = 4'h0;
   localparam logic [3:0] SRC_TB1M  = 4'h1;
   localparam logic [3:0] SRC_TB100 = 4'h5;
   localparam logic [3:0] SRC_PIN   = 4'h6;
   localparam logic [3:0] SRC_GATE  = 4'h7;
   localparam logic [3:0] SRC_FAST  = 4'h8;

   localparam logic [1:0] IDLE_HIZ  = 2'h0;
   localparam logic [1:0] IDLE_LOW  = 2'h1;
   localparam logic [1:0] IDLE_HIGH = 2'h2;

   localparam logic [2:0] OP_ARM     = 3'h1;
   localparam logic [2:0] OP_DISARM  = 3'h2;
   localparam logic [2:0] OP_RESTART = 3'h3;
   localparam logic [2:0] OP_SAVE    = 3'h4;

   typedef struct packed {
      logic       reload;
      logic [1:0] idle;
      logic       inv;
      logic       toggle;
      logic       down;
      logic [3:0] src;
      logic       falling;
      logic [3:0] gate;
   } mct_cfg_s;

   typedef struct packed {
      logic       en;
      logic [4:0] src;
      logic [3:0] div;
   } mct_freq_divider_output_s;

   // ==========================================================
   // Reset values
   localparam mct_cfg_s  CFG_RST  = 15'h0000;
   localparam mct_freq_divider_output_s FREQ_DIVIDER_OUTPUT_RST = 10'h000;
   localparam logic [15:0] LOAD_RST = 16'h0000;

endpackage

// ==== logic/mct_top.sv ====
// Added by the designer: the address map and the AHB-Lite interface to the registers.
`timescale 1ns/1ps
module mct_top
   import mct_pkg::*;
#(
   parameter int unsigned N_CNT = 10
)
(
   input  wire logic              mclk,
   input  wire logic              arst_n,
   input  wire logic              hsel,
   input  wire logic [31:0]       haddr,
   input  wire logic [1:0]        htrans,
   input  wire logic              hwrite,
   input  wire logic [2:0]        hsize,
   input  wire logic [31:0]       hwdata,
   input  wire logic              hready,
   output logic      [31:0]       hrdata,
   output logic                   hreadyout,
   output logic                   hresp,
   input  wire logic [N_CNT-1:0]  src_pin,
   input  wire logic [N_CNT-1:0]  gate_pin,
   output logic      [N_CNT-1:0]  cnt_out_o,
   output logic      [N_CNT-1:0]  cnt_out_oe,
   output logic      [N_FREQ_DIVIDER_OUTPUT-1:0] freq_divider_output
);

   // ==========================================================
   // Pin synchronisers
   logic [N_CNT-1:0] src_s1_r, src_s2_r, gate_s1_r, gate_s2_r;

   always_ff @(posedge mclk or negedge arst_n)
   begin
      if (!arst_n)
      begin
         src_s1_r  <= '0;
         src_s2_r  <= '0;
         gate_s1_r <= '0;
         gate_s2_r <= '0;
      end
      else
      begin
         src_s1_r  <= src_pin;
         src_s2_r  <= src_s1_r;
         gate_s1_r <= gate_pin;
         gate_s2_r <= gate_s1_r;
      end
   end

   // ==========================================================
   // Internal timebases
   logic [7:0] base_cnt_r;
   logic [5:0] fast_cnt_r;
   logic       fast_lvl_r;
   logic       hp_en [TB_LEVELS];
   logic       tb_lvl_r [TB_LEVELS];

   assign hp_en[0] = (base_cnt_r == 8'(TB_TOP_HALF - 1));

   always_ff @(posedge mclk or negedge arst_n)
   begin
      if (!arst_n)
      begin
         base_cnt_r <= '0;
         fast_cnt_r <= '0;
         fast_lvl_r <= 1'b0;
      end
      else
      begin
         base_cnt_r <= hp_en[0] ? '0 : base_cnt_r + 8'h01;
         if (fast_cnt_r == 6'(TB_FAST_HALF - 1))
         begin
            fast_cnt_r <= '0;
            fast_lvl_r <= ~fast_lvl_r;
         end
         else
            fast_cnt_r <= fast_cnt_r + 6'h01;
      end
   end

   for (genvar k = 0; k < TB_LEVELS; k++)
   begin : g_tb
      logic [3:0] dec_r;
      always_ff @(posedge mclk or negedge arst_n)
      begin
         if (!arst_n)
         begin
            dec_r       <= '0;
            tb_lvl_r[k] <= 1'b0;
         end
         else if (hp_en[k])
         begin
            tb_lvl_r[k] <= ~tb_lvl_r[k];
            dec_r       <= (dec_r == 4'(TB_DECADE - 1)) ? '0 : dec_r + 4'h1;
         end
      end
      if (k < TB_LEVELS - 1)
      begin : g_nx
         assign hp_en[k+1] = hp_en[k] && (dec_r == 4'(TB_DECADE - 1));
      end
   end

   // ==========================================================
   // AHB-Lite slave: zero wait states, always OKAY
   logic        acc, dph_wr_r;
   logic [11:0] dph_addr_r;
   logic [31:0] rd_mux;
   logic        wr_cmd;
   logic [2:0]  cmd_op;
   mct_cfg_s    cfg_r [N_CNT];
   mct_freq_divider_output_s   freq_divider_output_r [N_FREQ_DIVIDER_OUTPUT];
   logic [15:0] load_r [N_CNT];
   logic [15:0] hold_r [N_CNT];
   logic [15:0] cnt_r [N_CNT];
   logic        armed_r [N_CNT];
   logic        tc_r [N_CNT];
   logic        o_lvl [N_CNT];

   assign acc    = hsel && htrans[1] && hready;
   assign wr_cmd = dph_wr_r && (dph_addr_r == CMD_OFS);
   assign cmd_op = hwdata[CMD_OP_LSB +: 3];

   always_ff @(posedge mclk or negedge arst_n)
   begin
      if (!arst_n)
      begin
         dph_wr_r   <= 1'b0;
         dph_addr_r <= '0;
         hrdata     <= '0;
         hreadyout  <= 1'b1;
         hresp      <= 1'b0;
      end
      else
      begin
         hreadyout <= 1'b1;
         hresp     <= 1'b0;
         dph_wr_r  <= acc && hwrite;
         if (acc)
            dph_addr_r <= haddr[11:0];
         if (acc && !hwrite)
            hrdata <= rd_mux;
      end
   end

   always_comb
   begin
      logic [11:0] blk;
      rd_mux = '0;
      blk    = '0;
      if (haddr[11:0] == STATUS_OFS)
         for (int i = 0; i < N_CNT; i++)
         begin
            rd_mux[i]                = armed_r[i];
            rd_mux[STAT_OUT_LSB + i] = cnt_out_o[i];
         end
      else if (haddr[11:0] == FOUT0_OFS)
         rd_mux[9:0] = freq_divider_output_r[0];
      else if (haddr[11:0] == FOUT1_OFS)
         rd_mux[9:0] = freq_divider_output_r[1];
      for (int i = 0; i < N_CNT; i++)
      begin
         blk = 12'(CNT_BASE + CNT_STRIDE * i);
         if (haddr[11:4] == blk[11:4])
            unique case (haddr[3:0])
               CFG_OFS:   rd_mux[14:0] = cfg_r[i];
               LOAD_OFS:  rd_mux[15:0] = load_r[i];
               HOLD_OFS:  rd_mux[15:0] = hold_r[i];
               VALUE_OFS: rd_mux[15:0] = cnt_r[i];
               default:   rd_mux = '0;
            endcase
      end
   end

   always_ff @(posedge mclk or negedge arst_n)
   begin
      if (!arst_n)
      begin
         freq_divider_output_r[0] <= FREQ_DIVIDER_OUTPUT_RST;
         freq_divider_output_r[1] <= FREQ_DIVIDER_OUTPUT_RST;
      end
      else if (dph_wr_r)
      begin
         if (dph_addr_r == FOUT0_OFS)
            freq_divider_output_r[0] <= mct_freq_divider_output_s'(hwdata[9:0]);
         if (dph_addr_r == FOUT1_OFS)
            freq_divider_output_r[1] <= mct_freq_divider_output_s'(hwdata[9:0]);
      end
   end

   // ==========================================================
   // Counters
   // identical counter slices
   for (genvar i = 0; i < N_CNT; i++)
   begin : g_cnt
      localparam int LO = (i == 0) ? N_CNT - 1 : i - 1;
      localparam int HI = (i == N_CNT - 1) ? 0 : i + 1;
      localparam logic [11:0] BLK = 12'(CNT_BASE + CNT_STRIDE * i);
      logic        src_lvl, src_prev_r, tick, g_new, gate_q_r, g_edge;
      logic        edge_mode, active, at_tc, cmd_hit, wr_here, run_r, tog_r;
      logic [1:0]  budget_r;
      logic [15:0] reload_val;
      mct_cfg_s    c;

      assign c       = cfg_r[i];
      assign wr_here = dph_wr_r && (dph_addr_r[11:4] == BLK[11:4]);
      assign cmd_hit = wr_cmd && hwdata[i];
      assign g_new   = gate_s2_r[i];

      always_ff @(posedge mclk or negedge arst_n)
      begin
         if (!arst_n)
         begin
            cfg_r[i]  <= CFG_RST;
            load_r[i] <= LOAD_RST;
         end
         else if (wr_here)
         begin
            if (dph_addr_r[3:0] == CFG_OFS)
               cfg_r[i] <= mct_cfg_s'(hwdata[14:0]);
            if (dph_addr_r[3:0] == LOAD_OFS)
               load_r[i] <= hwdata[15:0];
         end
      end

      // source select, chain via lower output
      always_comb
      begin
         unique case (c.src)
            SRC_CHAIN: src_lvl = cnt_out_o[LO];
            4'h1:      src_lvl = tb_lvl_r[0];
            4'h2:      src_lvl = tb_lvl_r[1];
            4'h3:      src_lvl = tb_lvl_r[2];
            4'h4:      src_lvl = tb_lvl_r[3];
            SRC_TB100: src_lvl = tb_lvl_r[4];
            SRC_PIN:   src_lvl = src_s2_r[i];
            SRC_GATE:  src_lvl = g_new;
            SRC_FAST:  src_lvl = fast_lvl_r;
            default:   src_lvl = 1'b0;
         endcase
      end

      assign tick = c.falling ? (src_prev_r & ~src_lvl) : (~src_prev_r & src_lvl);

      // gate edge seen between two timebase samples
      assign edge_mode = (c.gate == GATE_RISE) || (c.gate == GATE_FALL);
      assign g_edge    = (c.gate == GATE_RISE) ? (g_new & ~gate_q_r) : (~g_new & gate_q_r);

      assign at_tc = c.down ? (cnt_r[i] == 16'h0000) : (cnt_r[i] == 16'hffff);

      assign reload_val = (c.gate == GATE_SPECIAL && g_new) ? hold_r[i] : load_r[i];

      always_comb
      begin
         unique case (c.gate)
            GATE_HIGH:  active = g_new;
            GATE_LOW:   active = ~g_new;
            GATE_RISE,
            GATE_FALL:  active = run_r;
            GATE_TC_LO: active = tc_r[LO];
            GATE_HI_UP: active = gate_s2_r[HI];
            GATE_HI_DN: active = gate_s2_r[LO];
            GATE_NONE,
            GATE_SPECIAL: active = 1'b1;
            default:    active = 1'b0;
         endcase
      end

      always_ff @(posedge mclk or negedge arst_n)
      begin
         if (!arst_n)
         begin
            src_prev_r <= 1'b0;
            gate_q_r   <= 1'b0;
            armed_r[i] <= 1'b0;
            run_r      <= 1'b0;
            budget_r   <= '0;
            cnt_r[i]   <= '0;
            hold_r[i]  <= '0;
            tc_r[i]    <= 1'b0;
            tog_r      <= 1'b0;
         end
         else
         begin
            src_prev_r <= src_lvl;
            if (wr_here && dph_addr_r[3:0] == HOLD_OFS)
               hold_r[i] <= hwdata[15:0];
            if (cmd_hit)
            begin
               unique case (cmd_op)
                  OP_ARM:     armed_r[i] <= 1'b1;
                  OP_DISARM:  armed_r[i] <= 1'b0;
                  OP_RESTART:
                  begin
                     armed_r[i] <= 1'b1;
                     cnt_r[i]   <= load_r[i];
                     run_r      <= 1'b0;
                     tc_r[i]    <= 1'b0;
                     tog_r      <= 1'b0;
                  end
                  OP_SAVE:    hold_r[i] <= cnt_r[i];
                  default:    armed_r[i] <= armed_r[i];
               endcase
            end
            // gate acts on the timebase edge that samples it
            else if (armed_r[i] && tick)
            begin
               gate_q_r <= g_new;
               // invert on the edge after terminal count
               tog_r    <= tog_r ^ tc_r[i];
               tc_r[i]  <= active && at_tc;
               // retriggerable one-shot: one output cycle per gate edge
               if (edge_mode && g_edge)
               begin
                  run_r    <= 1'b1;
                  cnt_r[i] <= load_r[i];
                  budget_r <= c.toggle ? 2'd2 : 2'd1;
                  tc_r[i]  <= 1'b0;
               end
               else if (active)
               begin
                  if (at_tc && (c.reload || c.gate == GATE_SPECIAL))
                     cnt_r[i] <= reload_val;
                  else
                     cnt_r[i] <= c.down ? cnt_r[i] - 16'h0001 : cnt_r[i] + 16'h0001;
                  if (at_tc && edge_mode)
                  begin
                     budget_r <= budget_r - 2'd1;
                     if (budget_r == 2'd1)
                        run_r <= 1'b0;
                  end
               end
            end
         end
      end

      assign o_lvl[i] = (c.toggle ? tog_r : tc_r[i]) ^ c.inv;
   end

   always_ff @(posedge mclk or negedge arst_n)
   begin
      if (!arst_n)
      begin
         cnt_out_o  <= '0;
         cnt_out_oe <= '0;
      end
      else
         for (int i = 0; i < N_CNT; i++)
         begin
            if (armed_r[i])
            begin
               cnt_out_o[i]  <= o_lvl[i];
               cnt_out_oe[i] <= 1'b1;
            end
            else
            begin
               cnt_out_o[i]  <= (cfg_r[i].idle == IDLE_HIGH);
               cnt_out_oe[i] <= (cfg_r[i].idle != IDLE_HIZ);
            end
         end
   end

   // ==========================================================
   // Frequency outputs, no counter used
   logic       f_lvl [N_FREQ_DIVIDER_OUTPUT];
   logic       f_prev_r [N_FREQ_DIVIDER_OUTPUT];
   logic [3:0] f_cnt_r [N_FREQ_DIVIDER_OUTPUT];

   always_comb
   begin
      for (int f = 0; f < N_FREQ_DIVIDER_OUTPUT; f++)
      begin
         f_lvl[f] = 1'b0;
         for (int k = 0; k < TB_LEVELS; k++)
            if (freq_divider_output_r[f].src == 5'(k))
               f_lvl[f] = tb_lvl_r[k];
         for (int i = 0; i < N_CNT; i++)
         begin
            if (freq_divider_output_r[f].src == 5'(TB_LEVELS + i))
               f_lvl[f] = src_s2_r[i];
            if (freq_divider_output_r[f].src == 5'(TB_LEVELS + N_CNT + i))
               f_lvl[f] = gate_s2_r[i];
         end
      end
   end

   // toggling every div edges keeps 50 percent duty; div 0 means 16
   always_ff @(posedge mclk or negedge arst_n)
   begin
      if (!arst_n)
      begin
         freq_divider_output <= '0;
         for (int f = 0; f < N_FREQ_DIVIDER_OUTPUT; f++)
         begin
            f_prev_r[f] <= 1'b0;
            f_cnt_r[f]  <= '0;
         end
      end
      else
         for (int f = 0; f < N_FREQ_DIVIDER_OUTPUT; f++)
         begin
            f_prev_r[f] <= f_lvl[f];
            if (!freq_divider_output_r[f].en)
            begin
               freq_divider_output[f] <= 1'b0;
               f_cnt_r[f]             <= '0;
            end
            else if (f_lvl[f] && !f_prev_r[f])
            begin
               if (f_cnt_r[f] == freq_divider_output_r[f].div - 4'h1)
               begin
                  f_cnt_r[f]             <= '0;
                  freq_divider_output[f] <= ~freq_divider_output[f];
               end
               else
                  f_cnt_r[f] <= f_cnt_r[f] + 4'h1;
            end
         end
   end

endmodule

// ==== test/mct_sig_model.sv ====
`timescale 1ns/1ps
// ==========================================
// Far-side pins: count pin bursts and gate levels
module mct_sig_model
#(
   parameter int unsigned N    = 2,
   parameter int unsigned HALF = 4
)
(
   input  wire logic         mclk,
   input  wire logic         arst_n,
   input  wire logic         go,
   input  wire logic [7:0]   num,
   input  wire logic [N-1:0] gate_req,
   output logic      [N-1:0] src_pin,
   output logic      [N-1:0] gate_pin,
   output logic              busy
);
   logic [7:0]  left_r;
   logic [15:0] tmr_r;

   // Pin 0 stands still between bursts; num counts level changes
   always_ff @(posedge mclk or negedge arst_n)
   begin
      if (!arst_n)
      begin
         src_pin  <= '0;
         gate_pin <= '0;
         left_r   <= 8'h00;
         tmr_r    <= 16'h0000;
      end
      else
      begin
         gate_pin <= gate_req;
         if (go && left_r == 8'h00)
         begin
            left_r <= num;
            tmr_r  <= 16'(HALF);
         end
         else if (left_r != 8'h00)
         begin
            if (tmr_r == 16'h0001)
            begin
               src_pin[0] <= ~src_pin[0];
               left_r     <= left_r - 8'h01;
               tmr_r      <= 16'(HALF);
            end
            else
               tmr_r <= tmr_r - 16'h0001;
         end
      end
   end

   assign busy = (left_r != 8'h00);
endmodule

// ==== test/mct_top_monitor.sv ====
`timescale 1ns/1ps
module mct_top_monitor
   import mct_pkg::*;
#(
   parameter int unsigned N_CNT = 10
)
(
   input wire logic              mclk,
   input wire logic              arst_n,
   input wire logic              hsel,
   input wire logic [31:0]       haddr,
   input wire logic [1:0]        htrans,
   input wire logic              hwrite,
   input wire logic [2:0]        hsize,
   input wire logic [31:0]       hwdata,
   input wire logic              hready,
   input wire logic [31:0]       hrdata,
   input wire logic              hreadyout,
   input wire logic              hresp,
   input wire logic [N_CNT-1:0]  src_pin,
   input wire logic [N_CNT-1:0]  gate_pin,
   input wire logic [N_CNT-1:0]  cnt_out_o,
   input wire logic [N_CNT-1:0]  cnt_out_oe,
   input wire logic [N_FREQ_DIVIDER_OUTPUT-1:0] freq_divider_output
);
   default clocking @(posedge mclk); endclocking
   default disable iff (!arst_n);

   // ==========================================
   // Data phase tracking
   logic        dp_v, dp_w, arm0, fint, f_q, wr, rd, cfg0wr, unmap, tog;
   logic [11:0] dp_a;
   logic [1:0]  idq, seen;
   int unsigned len, plen;

   assign wr     = dp_v & dp_w;
   assign rd     = dp_v & ~dp_w;
   assign cfg0wr = wr && dp_a == CNT_BASE + 12'(CFG_OFS);
   assign unmap  = (dp_a >= 12'h010 && dp_a < CNT_BASE) || dp_a >= CNT_BASE + 12'(16 * N_CNT);
   assign tog    = freq_divider_output[0] ^ f_q;

   always_ff @(posedge mclk or negedge arst_n)
   begin
      if (!arst_n)
      begin
         {dp_v, dp_w, dp_a, arm0, idq} <= '0;
         {fint, f_q, seen, len, plen}  <= '0;
      end
      else
      begin
         dp_v <= hsel & htrans[1] & hready;
         dp_w <= hwrite;
         dp_a <= haddr[11:0];
         f_q  <= freq_divider_output[0];
         len  <= tog ? 1 : len + 1;
         if (tog)
            plen <= len;
         if (tog && seen != 2'h2)
            seen <= seen + 2'h1;
         if (wr && dp_a == CMD_OFS && hwdata[0])
            arm0 <= (hwdata[18:16] == OP_ARM || hwdata[18:16] == OP_RESTART) ? 1'b1
                  : (hwdata[18:16] == OP_DISARM) ? 1'b0 : arm0;
         if (cfg0wr)
            idq <= hwdata[13:12];
         if (wr && dp_a == FOUT0_OFS)
         begin
            seen <= 2'h0;
            fint <= hwdata[8:4] < 5'h05;
         end
      end
   end

   // ==========================================
   // Assertions
   bus_okay_a: assert property (hreadyout && !hresp)
      else $error("bus answer not ready or not okay");
   rst_idle_a: assert property ($rose(arst_n) |-> cnt_out_oe == '0)
      else $error("output driven right after reset");
   rst_freq_divider_output_a: assert property ($rose(arst_n) |-> freq_divider_output == '0)
      else $error("frequency output high after reset");
   cmd_zero_a: assert property (rd && dp_a == CMD_OFS |-> hrdata == 32'h0)
      else $error("command register read not zero");
   unmap_zero_a: assert property (rd && unmap |-> hrdata == 32'h0)
      else $error("unmapped read not zero");
   idle_state_a: assert property (cfg0wr && !arm0 |-> ##[1:3]
      (cnt_out_oe[0] == (idq != IDLE_HIZ) && cnt_out_o[0] == (idq == IDLE_HIGH)))
      else $error("idle output state wrong");
   freq_divider_output_off_a: assert property (wr && dp_a == FOUT0_OFS && !hwdata[9]
      |-> ##3 (!freq_divider_output[0]) [*4])
      else $error("disabled frequency output not low");
   freq_divider_output_duty_a: assert property (tog && seen == 2'h2 && fint |-> len == plen)
      else $error("frequency output halves unequal");

   cover property (tog && seen == 2'h2 && fint);
   cover property (cfg0wr && !arm0);
   cover property (rd && unmap);
endmodule

bind mct_top mct_top_monitor #(.N_CNT(N_CNT)) mct_top_monitor_i (
   .mclk(mclk), .arst_n(arst_n), .hsel(hsel), .haddr(haddr), .htrans(htrans),
   .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata), .hready(hready), .hrdata(hrdata),
   .hreadyout(hreadyout), .hresp(hresp), .src_pin(src_pin), .gate_pin(gate_pin),
   .cnt_out_o(cnt_out_o), .cnt_out_oe(cnt_out_oe), .freq_divider_output(freq_divider_output));

// ==== test/multi_counter_timer_unit_tb.sv ====
`timescale 1ns/1ps
module multi_counter_timer_unit_tb
   import mct_pkg::*;
;
   logic        mclk = 1'b0, arst_n = 1'b0, hsel = 1'b0, hwrite = 1'b0, go = 1'b0;
   logic [31:0] haddr = '0, hwdata = '0;
   logic [1:0]  htrans = 2'h0, gate_req = 2'h0;
   logic [7:0]  num = 8'h00;
   wire  logic  hready, hresp, busy;
   wire  logic [31:0] hrdata;
   wire  logic [1:0]  src_pin, gate_pin, cnt_out_o, cnt_out_oe, freq_divider_output;
   int errors = 0, comparisons = 0, n, k;
   logic [31:0] e5 [2] = '{32'h1, 32'h0};
   logic [31:0] ei [3] = '{32'h0, 32'h2, 32'h3};

   initial forever #2.5 mclk = ~mclk;

   mct_top #(.N_CNT(2)) mct_top_i (.mclk(mclk), .arst_n(arst_n), .hsel(hsel),
      .haddr(haddr), .htrans(htrans), .hwrite(hwrite), .hsize(3'h2), .hwdata(hwdata),
      .hready(hready), .hrdata(hrdata), .hreadyout(hready), .hresp(hresp),
      .src_pin(src_pin), .gate_pin(gate_pin), .cnt_out_o(cnt_out_o),
      .cnt_out_oe(cnt_out_oe), .freq_divider_output(freq_divider_output));
   mct_sig_model mct_sig_model_i (.mclk(mclk), .arst_n(arst_n), .go(go), .num(num),
      .gate_req(gate_req), .src_pin(src_pin), .gate_pin(gate_pin), .busy(busy));

   // ==========================================
   // Bus and check tasks
   function automatic logic [31:0] ca(input int i, input logic [3:0] o);
      return 32'(CNT_BASE) + 32'(CNT_STRIDE) * 32'(i) + 32'(o);
   endfunction
   function automatic logic [31:0] cw(input logic [3:0] g, input logic [3:0] s,
                                      input logic f, input logic dn, input logic [1:0] idl);
      return 32'({1'b0, idl, 2'h0, dn, s, f, g});
   endfunction
   task automatic tmo();
      errors++;
      $display("Error at %0t: wait ran out, got %h expected %h", $time, 1'b0, 1'b1);
      tally_and_finish();
   endtask
   task automatic rdy();
      int c;
      c = 0;
      do begin @(posedge mclk); c++; end while (hready !== 1'b1 && c < 64);
      if (hready !== 1'b1) tmo();
   endtask
   task automatic wr(input logic [31:0] a, input logic [31:0] d);
      hsel <= 1'b1; haddr <= a; htrans <= 2'h2; hwrite <= 1'b1;
      rdy();
      hsel <= 1'b0; htrans <= 2'h0; hwdata <= d;
      rdy();
   endtask
   task automatic chk(input logic [31:0] g, input logic [31:0] e);
      comparisons++;
      if (g !== e) begin errors++; $display("Error at %0t: got %h expected %h", $time, g, e); end
   endtask
   task automatic rchk(input logic [31:0] a, input logic [31:0] e);
      hsel <= 1'b1; haddr <= a; htrans <= 2'h2; hwrite <= 1'b0;
      rdy();
      hsel <= 1'b0; htrans <= 2'h0;
      rdy();
      chk(hrdata, e);
   endtask
   task automatic cmd(input logic [15:0] m, input logic [2:0] op);
      wr(32'(CMD_OFS), {13'h0, op, m});
   endtask
   // Level changes on count pin 0, then time for sync and tick
   task automatic edges(input logic [7:0] t);
      int c;
      go <= 1'b1; num <= t;
      @(posedge mclk);
      go <= 1'b0;
      c = 0;
      do begin @(posedge mclk); c++; end while (busy === 1'b1 && c < 2000);
      if (busy === 1'b1) tmo();
      repeat (8) @(posedge mclk);
   endtask
   task automatic half(output int c);
      logic w;
      w = freq_divider_output[0];
      c = 0;
      do begin @(negedge mclk); c++; end while (freq_divider_output[0] === w && c < 5000);
      if (c >= 5000) tmo();
   endtask
   task automatic tally_and_finish();
      $display("comparisons %0d errors %0d", comparisons, errors);
      if (errors == 0 && comparisons > 0)
         $display("[ PASS ]");
      else
         $display("[ FAIL ]");
      $finish;
   endtask

   // ==========================================
   // Scenarios
   initial
   begin
      repeat (6) @(posedge mclk);
      arst_n <= 1'b1;
      @(posedge mclk);
      rchk(32'(STATUS_OFS), 32'h0);
      rchk(ca(0, CFG_OFS), 32'(CFG_RST));
      rchk(ca(1, LOAD_OFS), 32'(LOAD_RST));
      rchk(32'(FOUT0_OFS), 32'(FREQ_DIVIDER_OUTPUT_RST));
      wr(32'h014, 32'h5a5a);
      rchk(32'h014, 32'h0);
      rchk(32'(CMD_OFS), 32'h0);
      wr(ca(1, CFG_OFS), 32'h7fff);
      rchk(ca(1, CFG_OFS), 32'h7fff);
      chk(32'(cnt_out_oe), 32'h2);
      $display("test registers done");
      for (k = 0; k < 3; k++)
      begin
         wr(ca(0, CFG_OFS), cw(GATE_NONE, SRC_PIN, 1'b0, 1'b0, 2'(k)));
         repeat (4) @(posedge mclk);
         @(negedge mclk);
         chk(32'({cnt_out_oe[0], cnt_out_o[0]}), ei[k]);
         @(posedge mclk);
      end
      rchk(32'(STATUS_OFS), 32'h10000);
      $display("test idle done");
      for (k = 0; k < 2; k++)
      begin
         wr(ca(0, CFG_OFS), cw(GATE_NONE, SRC_PIN, 1'(k), 1'b0, IDLE_HIZ));
         wr(ca(0, LOAD_OFS), 32'hfffe);
         cmd(16'h1, OP_RESTART);
         edges(8'd5);
         rchk(ca(0, VALUE_OFS), e5[k]);
         edges(8'd1);
         rchk(ca(0, VALUE_OFS), 32'h1);
      end
      rchk(32'(STATUS_OFS), 32'h1);
      cmd(16'h1, OP_SAVE);
      rchk(ca(0, HOLD_OFS), 32'h1);
      cmd(16'h1, OP_DISARM);
      edges(8'd2);
      rchk(ca(0, VALUE_OFS), 32'h1);
      rchk(32'(STATUS_OFS), 32'h0);
      cmd(16'h1, OP_ARM);
      edges(8'd2);
      rchk(ca(0, VALUE_OFS), 32'h2);
      $display("test counting done");
      for (k = 0; k < 2; k++)
      begin
         gate_req <= {1'b0, 1'(k)};
         wr(ca(0, CFG_OFS), cw(k == 0 ? GATE_HIGH : GATE_LOW, SRC_PIN, 1'b0, 1'b1, IDLE_HIZ));
         wr(ca(0, LOAD_OFS), 32'h3);
         cmd(16'h1, OP_RESTART);
         edges(8'd4);
         rchk(ca(0, VALUE_OFS), 32'h3);
         gate_req <= {1'b0, 1'(1 - k)};
         repeat (8) @(posedge mclk);
         edges(8'd4);
         rchk(ca(0, VALUE_OFS), 32'h1);
      end
      $display("test gating done");
      gate_req <= 2'h0;
      wr(ca(0, CFG_OFS), cw(GATE_NONE, SRC_PIN, 1'b0, 1'b0, IDLE_HIZ));
      wr(ca(0, LOAD_OFS), 32'hffff);
      wr(ca(1, CFG_OFS), cw(GATE_NONE, SRC_CHAIN, 1'b0, 1'b0, IDLE_HIZ));
      wr(ca(1, LOAD_OFS), 32'h0);
      cmd(16'h3, OP_RESTART);
      edges(8'd2);
      rchk(ca(0, VALUE_OFS), 32'h0);
      rchk(ca(1, VALUE_OFS), 32'h1);
      cmd(16'h3, OP_DISARM);
      $display("test chain done");
      // Toggle form, inverted: one flip after terminal count drives the pin low
      wr(ca(0, CFG_OFS), 32'hc00 | cw(GATE_NONE, SRC_PIN, 1'b0, 1'b0, IDLE_HIZ));
      cmd(16'h1, OP_RESTART);
      edges(8'd4);
      rchk(32'(STATUS_OFS), 32'h1);
      // Own gate high, upper neighbour's gate low: must hold
      gate_req <= 2'h1;
      wr(ca(0, CFG_OFS), cw(GATE_HI_UP, SRC_PIN, 1'b0, 1'b0, IDLE_HIZ));
      cmd(16'h1, OP_RESTART);
      edges(8'd2);
      rchk(ca(0, VALUE_OFS), 32'hffff);
      gate_req <= 2'h2;
      repeat (8) @(posedge mclk);
      edges(8'd2);
      rchk(ca(0, VALUE_OFS), 32'h0);
      $display("test modes done");
      wr(32'(FOUT0_OFS), 32'h202);
      half(n);
      half(n);
      chk(32'(n), 32'(2 * 2 * TB_TOP_HALF));
      half(n);
      chk(32'(n), 32'(2 * 2 * TB_TOP_HALF));
      @(posedge mclk);
      wr(32'(FOUT0_OFS), 32'h002);
      repeat (8) @(posedge mclk);
      chk(32'(freq_divider_output), 32'h0);
      $display("test frequency done");
      tally_and_finish();
   end
endmodule
